/* design/clkgen_pkg.sv */
// Purpose: Shared constants for the clock generator serial control link.
// Assumes: Core clock of 200 MHz; one shared reset.
// Notes:   Both link ends and the bench read these values.
package clkgen_pkg;
   // Core clock and generated serial clock timing.
   localparam int CORE_CLK_PERIOD_NS = 5;
   // A short serial period keeps one transfer under two thousand core cycles.
   localparam int SCL_PERIOD_NS      = 200;
   localparam int SCL_QTR_CYCLES     = SCL_PERIOD_NS / (4 * CORE_CLK_PERIOD_NS);
   localparam int QTR_CNT_W          = 10;

   // Link framing.
   localparam logic [7:0] TARGET_ADDR_WR = 8'hD2;
   localparam logic [7:0] TARGET_ADDR_RD = 8'hD3;
   localparam logic [7:0] BYTE_OP_CMD    = 8'h80;
   localparam int         DIR_BIT        = 0;
   localparam int         BYTE_OP_BIT    = 7;
   localparam int         BYTE_BITS      = 8;
   localparam int         ACK_SLOT       = 8;

   // Control bytes of the target.
   localparam int         NUM_CTRL_BYTES = 4;
   localparam int         INDEX_W        = 2;
   localparam logic [1:0] OUTPUT_ENABLE_CONTROL_IDX   = 2'h0;
   localparam logic [1:0] RESERVED_CONTROL_ONE_IDX    = 2'h1;
   localparam logic [1:0] SPREAD_SPECTRUM_CONTROL_IDX = 2'h2;
   localparam logic [1:0] RESERVED_CONTROL_THREE_IDX  = 2'h3;
   localparam logic [7:0] CTRL_RESET [NUM_CTRL_BYTES] = '{8'h7C, 8'h00, 8'hEA, 8'h00};
   localparam int         NUM_OUTPUTS        = 4;
   localparam int         OUTPUT0_ENABLE_BIT = 3;
   localparam int         SPREAD_DEEP_BIT    = 7;
   localparam int         SPREAD_ENABLE_BIT  = 2;

   // Controller command registers.
   localparam logic [1:0] CMD_OFS       = 2'h0;
   localparam logic [1:0] WDATA_OFS     = 2'h1;
   localparam logic [1:0] RDATA_OFS     = 2'h2;
   localparam logic [1:0] STATUS_OFS    = 2'h3;
   localparam int         CMD_GO_BIT    = 0;
   localparam int         CMD_READ_BIT  = 1;
   localparam int         CMD_INDEX_LSB = 2;
   localparam int         STAT_BUSY_BIT = 0;
   localparam int         STAT_NACK_BIT = 1;

   // Transfer steps of the controller.
   localparam logic [2:0] STEP_START   = 3'h0;
   localparam logic [2:0] STEP_ADDR    = 3'h1;
   localparam logic [2:0] STEP_CMD     = 3'h2;
   localparam logic [2:0] STEP_DATA    = 3'h3;
   localparam logic [2:0] STEP_WR_STOP = 3'h4;
   localparam logic [2:0] STEP_RX      = 3'h5;
   localparam logic [2:0] STEP_RD_STOP = 3'h6;
endpackage

/* design/two_wire_if.sv */
// Purpose: Open-drain two-wire link between controller and target.
// Assumes: Both lines have pull-ups; a released line reads high.
// Notes:   Output enables are active low; the wire level is resolved here.
`timescale 1ns/10ps
interface two_wire_if;
   logic scl_out;
   logic scl_oe_n;
   logic sda_ctl_out;
   logic sda_ctl_oe_n;
   logic sda_tgt_out;
   logic sda_tgt_oe_n;
   logic scl;
   logic sda;

   assign scl = scl_oe_n | scl_out;
   assign sda = (sda_ctl_oe_n | sda_ctl_out) & (sda_tgt_oe_n | sda_tgt_out);

   modport controller (output scl_out, scl_oe_n, sda_ctl_out, sda_ctl_oe_n, input scl, sda);
   modport target (output sda_tgt_out, sda_tgt_oe_n, input scl, sda);
endinterface // two_wire_if

/* design/pin_sync.sv */
// Purpose: Two-flop synchroniser with edge pulses for a link pin.
// Assumes: Idle level of the pin is high.
// Notes:   Edges are taken from the second and third flops only.
`timescale 1ns/10ps
module pin_sync
(
   // Clock and reset.
   input  logic core_clk,
   input  logic rst,
   // Pin and its synchronised views.
   input  logic pin_in,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta_reg;
   logic level_reg;
   logic prev_reg;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         meta_reg  <= 1'b1;
         level_reg <= 1'b1;
         prev_reg  <= 1'b1;
      end
      else
      begin
         meta_reg  <= pin_in;
         level_reg <= meta_reg;
         prev_reg  <= level_reg;
      end
   end

   assign level = level_reg;
   assign rise  = level_reg & ~prev_reg;
   assign fall  = ~level_reg & prev_reg;
endmodule // pin_sync

/* design/clkgen_target.sv */
// Purpose: Serial target of the clock generator with its control bytes.
// Assumes: Controller drives the serial clock; no clock stretching here.
// Notes:   Clock outputs are modelled as a 100 MHz toggle of the core clock.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module clkgen_target
   import clkgen_pkg::*;
(
   // Clock and reset.
   input  logic                   core_clk,
   input  logic                   rst,
   // Serial link.
   two_wire_if.target             link,
   // Differential clock outputs, enables active low.
   output logic [NUM_OUTPUTS-1:0] diff_output_p,
   output logic [NUM_OUTPUTS-1:0] diff_output_n,
   output logic [NUM_OUTPUTS-1:0] diff_output_oe_n,
   // Spread settings for the synthesiser.
   output logic                   spread_enable,
   output logic                   spread_deep
);
   typedef enum {st_idle, st_addr, st_cmd, st_wdata, st_ack, st_send, st_mack, st_wait}
      tgt_state_type;

   tgt_state_type          state_reg;
   tgt_state_type          after_reg;
   tgt_state_type          after_next;
   logic [3:0]             bit_cnt_reg;
   logic [7:0]             shift_reg;
   logic [INDEX_W-1:0]     index_reg;
   logic                   ack_due_reg;
   logic                   sda_oe_n_reg;
   logic [7:0]             ctrl_regs [NUM_CTRL_BYTES];
   logic [NUM_OUTPUTS-1:0] p_reg;
   logic [NUM_OUTPUTS-1:0] n_reg;
   logic [NUM_OUTPUTS-1:0] oe_n_reg;
   logic                   spread_enable_reg;
   logic                   spread_deep_reg;
   logic                   scl_lvl;
   logic                   scl_rise;
   logic                   scl_fall;
   logic                   sda_lvl;
   logic                   sda_rise;
   logic                   sda_fall;
   logic                   start_ev;
   logic                   stop_ev;
   logic                   rx_state;
   logic                   byte_done;
   logic                   accept;
   logic [7:0]             byte_now;

   pin_sync scl_sync
   (
      .core_clk (core_clk),
      .rst      (rst),
      .pin_in   (link.scl),
      .level    (scl_lvl),
      .rise     (scl_rise),
      .fall     (scl_fall)
   );

   pin_sync sda_sync
   (
      .core_clk (core_clk),
      .rst      (rst),
      .pin_in   (link.sda),
      .level    (sda_lvl),
      .rise     (sda_rise),
      .fall     (sda_fall)
   );

   // Both lines share the same sync delay, so their relative order is kept.
   assign start_ev  = sda_fall & scl_lvl;
   assign stop_ev   = sda_rise & scl_lvl;
   assign rx_state  = (state_reg == st_addr) || (state_reg == st_cmd) || (state_reg == st_wdata);
   assign byte_now  = {shift_reg[6:0], sda_lvl};
   assign byte_done = rx_state && scl_rise && (bit_cnt_reg == 4'(BYTE_BITS - 1));

   always_comb
   begin
      accept     = 1'b0;
      after_next = st_wait;
      if (state_reg == st_addr)
      begin
         if (byte_now[7:1] == TARGET_ADDR_WR[7:1])
         begin
            accept     = 1'b1;
            after_next = byte_now[DIR_BIT] ? st_send : st_cmd;
         end
      end
      else if (state_reg == st_cmd)
      begin
         if (byte_now[BYTE_OP_BIT])
         begin
            accept     = 1'b1;
            after_next = st_wdata;
         end
      end
      else if (state_reg == st_wdata)
      begin
         accept = 1'b1;
      end
   end

   // Link sequencer: receives bytes, answers in the ack slot, sends read data.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_reg    <= st_idle;
         after_reg    <= st_wait;
         bit_cnt_reg  <= 4'h0;
         shift_reg    <= 8'h00;
         index_reg    <= '0;
         ack_due_reg  <= 1'b0;
         sda_oe_n_reg <= 1'b1;
      end
      else if (start_ev)
      begin
         state_reg    <= st_addr;
         bit_cnt_reg  <= 4'h0;
         ack_due_reg  <= 1'b0;
         sda_oe_n_reg <= 1'b1;
      end
      else if (stop_ev)
      begin
         state_reg    <= st_idle;
         ack_due_reg  <= 1'b0;
         sda_oe_n_reg <= 1'b1;
      end
      else
      begin
         unique case (state_reg)
            st_addr, st_cmd, st_wdata:
            begin
               if (scl_rise)
               begin
                  shift_reg   <= byte_now;
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
               if (byte_done)
               begin
                  ack_due_reg <= accept;
                  after_reg   <= after_next;
                  if (!accept)
                  begin
                     state_reg <= st_wait;
                  end
                  if (state_reg == st_cmd && accept)
                  begin
                     index_reg <= byte_now[INDEX_W-1:0];
                  end
                  if (state_reg == st_addr && accept && byte_now[DIR_BIT])
                  begin
                     shift_reg <= ctrl_regs[index_reg];
                  end
               end
               if (scl_fall && ack_due_reg)
               begin
                  sda_oe_n_reg <= 1'b0;
                  ack_due_reg  <= 1'b0;
                  state_reg    <= st_ack;
               end
            end
            st_ack:
            begin
               if (scl_fall)
               begin
                  state_reg   <= after_reg;
                  bit_cnt_reg <= 4'h0;
                  if (after_reg == st_send)
                  begin
                     sda_oe_n_reg <= shift_reg[7];
                     shift_reg    <= {shift_reg[6:0], 1'b1};
                  end
                  else
                  begin
                     sda_oe_n_reg <= 1'b1;
                  end
               end
            end
            st_send:
            begin
               if (scl_rise)
               begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
               if (scl_fall)
               begin
                  if (bit_cnt_reg == 4'(BYTE_BITS))
                  begin
                     sda_oe_n_reg <= 1'b1;
                     state_reg    <= st_mack;
                  end
                  else
                  begin
                     sda_oe_n_reg <= shift_reg[7];
                     shift_reg    <= {shift_reg[6:0], 1'b1};
                  end
               end
            end
            st_mack:
            begin
               // Only single-byte reads exist, so any answer ends the read.
               if (scl_rise)
               begin
                  state_reg <= st_wait;
               end
            end
            st_idle, st_wait:
            begin
            end
         endcase
      end
   end

   // Control bytes, written whole so reserved bits read back as written.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < NUM_CTRL_BYTES; i++)
         begin
            ctrl_regs[i] <= CTRL_RESET[i];
         end
      end
      else if (byte_done && state_reg == st_wdata)
      begin
         ctrl_regs[index_reg] <= byte_now;
      end
   end

   // Output clock; enables change only as the clock falls, so no pulse is cut.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         p_reg    <= '0;
         n_reg    <= '1;
         oe_n_reg <= ~CTRL_RESET[OUTPUT_ENABLE_CONTROL_IDX][OUTPUT0_ENABLE_BIT +: NUM_OUTPUTS];
      end
      else
      begin
         p_reg <= ~p_reg;
         n_reg <= p_reg;
         if (p_reg[0])
         begin
            oe_n_reg <= ~ctrl_regs[OUTPUT_ENABLE_CONTROL_IDX][OUTPUT0_ENABLE_BIT +: NUM_OUTPUTS];
         end
      end
   end

   // Spread settings for the synthesiser.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         spread_enable_reg <= CTRL_RESET[SPREAD_SPECTRUM_CONTROL_IDX][SPREAD_ENABLE_BIT];
         spread_deep_reg   <= CTRL_RESET[SPREAD_SPECTRUM_CONTROL_IDX][SPREAD_DEEP_BIT];
      end
      else
      begin
         spread_enable_reg <= ctrl_regs[SPREAD_SPECTRUM_CONTROL_IDX][SPREAD_ENABLE_BIT];
         spread_deep_reg   <= ctrl_regs[SPREAD_SPECTRUM_CONTROL_IDX][SPREAD_DEEP_BIT];
      end
   end

   assign link.sda_tgt_out  = 1'b0;
   assign link.sda_tgt_oe_n = sda_oe_n_reg;
   assign diff_output_p     = p_reg;
   assign diff_output_n     = n_reg;
   assign diff_output_oe_n  = oe_n_reg;
   assign spread_enable     = spread_enable_reg;
   assign spread_deep       = spread_deep_reg;
endmodule // clkgen_target

/* design/serial_controller.sv */
// Purpose: Two-wire bus controller issuing single-byte writes and reads.
// Assumes: Target never stretches the serial clock.
// Notes:   Software drives it through four byte-wide registers.
`timescale 1ns/10ps
module serial_controller
   import clkgen_pkg::*;
(
   // Clock and reset.
   input  logic       core_clk,
   input  logic       rst,
   // Register port.
   input  logic [1:0] reg_addr,
   input  logic [7:0] reg_wdata,
   input  logic       reg_wr,
   input  logic       reg_rd,
   output logic [7:0] reg_rdata,
   // Serial link.
   two_wire_if.controller link
);
   typedef enum {st_idle, st_start, st_byte, st_stop} seq_state_type;

   seq_state_type        state_reg;
   logic [2:0]           step_reg;
   logic [3:0]           bit_reg;
   logic [1:0]           q_reg;
   logic [QTR_CNT_W-1:0] qtr_cnt_reg;
   logic [7:0]           shift_reg;
   logic [7:0]           wdata_reg;
   logic [7:0]           rdata_reg;
   logic [7:0]           reg_rdata_reg;
   logic [INDEX_W-1:0]   index_reg;
   logic                 read_reg;
   logic                 busy_reg;
   logic                 nack_reg;
   logic                 scl_oe_n_reg;
   logic                 sda_oe_n_reg;
   logic                 sda_lvl;
   logic                 tick;
   logic                 go;
   logic                 rx;

   function automatic seq_state_type item_kind(input logic [2:0] step, input logic rd);
      if (step == STEP_START || (rd && step == STEP_DATA))
         return st_start;
      if ((!rd && step == STEP_WR_STOP) || (rd && step == STEP_RD_STOP))
         return st_stop;
      return st_byte;
   endfunction

   function automatic logic [7:0] tx_byte(input logic [2:0] step, input logic rd,
                                          input logic [INDEX_W-1:0] idx, input logic [7:0] wd);
      if (step == STEP_ADDR)
         return TARGET_ADDR_WR;
      if (step == STEP_CMD)
         return BYTE_OP_CMD | {6'h00, idx};
      if (step == STEP_DATA && !rd)
         return wd;
      return TARGET_ADDR_RD;
   endfunction

   pin_sync sda_sync
   (
      .core_clk (core_clk),
      .rst      (rst),
      .pin_in   (link.sda),
      .level    (sda_lvl),
      .rise     (),
      .fall     ()
   );

   assign tick = qtr_cnt_reg == QTR_CNT_W'(SCL_QTR_CYCLES - 1);
   assign go   = reg_wr && reg_addr == CMD_OFS && reg_wdata[CMD_GO_BIT] && !busy_reg;
   assign rx   = read_reg && step_reg == STEP_RX;

   always_ff @(posedge core_clk)
   begin
      if (rst || tick)
         qtr_cnt_reg <= '0;
      else
         qtr_cnt_reg <= qtr_cnt_reg + QTR_CNT_W'(1);
   end

   // Software-written command fields; a go while busy is ignored.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         wdata_reg <= 8'h00;
         read_reg  <= 1'b0;
         index_reg <= '0;
      end
      else
      begin
         if (reg_wr && reg_addr == WDATA_OFS)
            wdata_reg <= reg_wdata;
         if (go)
         begin
            read_reg  <= reg_wdata[CMD_READ_BIT];
            index_reg <= reg_wdata[CMD_INDEX_LSB +: INDEX_W];
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst || !reg_rd)
         reg_rdata_reg <= 8'h00;
      else
         unique case (reg_addr)
            CMD_OFS:    reg_rdata_reg <= {4'h0, index_reg, read_reg, 1'b0};
            WDATA_OFS:  reg_rdata_reg <= wdata_reg;
            RDATA_OFS:  reg_rdata_reg <= rdata_reg;
            STATUS_OFS: reg_rdata_reg <= {6'h00, nack_reg, busy_reg};
         endcase
   end

   // Bit sequencer: each bit is four quarter periods of the serial clock.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_reg    <= st_idle;
         step_reg     <= STEP_START;
         bit_reg      <= 4'h0;
         q_reg        <= 2'h0;
         shift_reg    <= 8'h00;
         rdata_reg    <= 8'h00;
         busy_reg     <= 1'b0;
         nack_reg     <= 1'b0;
         scl_oe_n_reg <= 1'b1;
         sda_oe_n_reg <= 1'b1;
      end
      else if (state_reg == st_idle)
      begin
         if (go)
         begin
            state_reg <= st_start;
            step_reg  <= STEP_START;
            q_reg     <= 2'h0;
            busy_reg  <= 1'b1;
            nack_reg  <= 1'b0;
         end
      end
      else if (tick)
      begin
         q_reg <= q_reg + 2'h1;
         unique case (state_reg)
            st_start:
               unique case (q_reg)
                  2'h0: sda_oe_n_reg <= 1'b1;
                  2'h1: scl_oe_n_reg <= 1'b1;
                  2'h2: sda_oe_n_reg <= 1'b0;
                  2'h3:
                  begin
                     scl_oe_n_reg <= 1'b0;
                     step_reg     <= step_reg + 3'h1;
                     state_reg    <= item_kind(step_reg + 3'h1, read_reg);
                     shift_reg    <= tx_byte(step_reg + 3'h1, read_reg, index_reg, wdata_reg);
                     bit_reg      <= 4'h0;
                  end
               endcase
            st_byte:
               unique case (q_reg)
                  2'h0: sda_oe_n_reg <= (rx || bit_reg == 4'(ACK_SLOT)) ? 1'b1 : shift_reg[7];
                  2'h1: scl_oe_n_reg <= 1'b1;
                  2'h2:
                  begin
                     if (rx && bit_reg != 4'(ACK_SLOT))
                        shift_reg <= {shift_reg[6:0], sda_lvl};
                     if (!rx && bit_reg == 4'(ACK_SLOT) && sda_lvl)
                        nack_reg <= 1'b1;
                  end
                  2'h3:
                  begin
                     scl_oe_n_reg <= 1'b0;
                     if (!rx)
                        shift_reg <= {shift_reg[6:0], 1'b1};
                     if (bit_reg != 4'(ACK_SLOT))
                        bit_reg <= bit_reg + 4'h1;
                     else if (nack_reg)
                        state_reg <= st_stop;
                     else
                     begin
                        if (rx)
                           rdata_reg <= shift_reg;
                        step_reg  <= step_reg + 3'h1;
                        state_reg <= item_kind(step_reg + 3'h1, read_reg);
                        shift_reg <= tx_byte(step_reg + 3'h1, read_reg, index_reg, wdata_reg);
                        bit_reg   <= 4'h0;
                     end
                  end
               endcase
            st_stop:
               unique case (q_reg)
                  2'h0: sda_oe_n_reg <= 1'b0;
                  2'h1: scl_oe_n_reg <= 1'b1;
                  2'h2: sda_oe_n_reg <= 1'b1;
                  2'h3:
                  begin
                     state_reg <= st_idle;
                     busy_reg  <= 1'b0;
                  end
               endcase
            st_idle:
            begin
            end
         endcase
      end
   end

   assign reg_rdata         = reg_rdata_reg;
   assign link.scl_out      = 1'b0;
   assign link.scl_oe_n     = scl_oe_n_reg;
   assign link.sda_ctl_out  = 1'b0;
   assign link.sda_ctl_oe_n = sda_oe_n_reg;
endmodule // serial_controller

/* verif/link_checker.sv */
// Purpose: Wire-level checks of the two-wire control link.
// Assumes: Both ends are design modules on one core clock.
// Notes:   Bit slots are counted from the last start condition.
`timescale 1ns/10ps
module link_checker
(
   // Clock and reset.
   input logic core_clk,
   input logic rst,
   // Wire levels and target drive.
   input logic scl,
   input logic sda,
   input logic sda_tgt_oe_n
);
   logic [5:0] slot_reg;
   logic       dir_reg;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // A repeated start clears the count as well, so read frames restart at the address.
   always_ff @(posedge core_clk)
   begin
      if (rst || (scl && $fell(sda)))
         slot_reg <= 6'h00;
      else if ($rose(scl))
         slot_reg <= slot_reg + 6'h01;
   end

   always_ff @(posedge core_clk)
   begin
      if ($rose(scl) && slot_reg == 6'h07)
         dir_reg <= sda;
   end

   start_by_ctl_a: assert property (scl && $fell(sda) |-> sda_tgt_oe_n)
      else $error("start made by target");
   stop_by_ctl_a: assert property (scl && $rose(sda) |-> $past(sda_tgt_oe_n))
      else $error("stop made by target");
   addr_ack_a: assert property ($rose(scl) && slot_reg == 6'h08 |-> !sda)
      else $error("address not acknowledged");
   cmd_ack_a: assert property ($rose(scl) && slot_reg == 6'h11 && !dir_reg |-> !sda)
      else $error("command not acknowledged");
   data_ack_a: assert property ($rose(scl) && slot_reg == 6'h1A && !dir_reg |-> !sda)
      else $error("data not acknowledged");
   read_nack_a: assert property ($rose(scl) && slot_reg == 6'h11 && dir_reg |-> sda)
      else $error("read byte not refused");
   ack_release_a: assert property ($rose(scl) && slot_reg == 6'h09 && !dir_reg
                                   |-> sda_tgt_oe_n)
      else $error("target held line after ack");
   tgt_edge_a: assert property ($changed(sda_tgt_oe_n) |-> !scl)
      else $error("target changed line while clock high");
   bit_hold_a: assert property ($rose(scl) |=> $stable(sda) [*8])
      else $error("data moved while clock high");
endmodule // link_checker

/* verif/tb.sv */
// Purpose: Self-checking bench joining controller and target over the link.
// Assumes: Fast serial clock, so each transfer takes under two thousand cycles.
// Notes:   Expected bytes keep reserved bits at their power-up values.
`timescale 1ns/10ps
module tb
   import clkgen_pkg::*;
;
   logic       core_clk;
   logic       rst;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic [3:0] diff_output_p;
   logic [3:0] diff_output_n;
   logic [3:0] diff_output_oe_n;
   logic       spread_enable;
   logic       spread_deep;
   logic [7:0] got;
   int         miscompares;
   int         compares;

   localparam int POLL_LIMIT = 2000;

   two_wire_if u_two_wire_if ();
   serial_controller u_serial_controller (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .link(u_two_wire_if));
   clkgen_target u_clkgen_target (.core_clk, .rst, .link(u_two_wire_if), .diff_output_p,
      .diff_output_n, .diff_output_oe_n, .spread_enable, .spread_deep);
   link_checker u_link_checker (.core_clk, .rst, .scl(u_two_wire_if.scl),
      .sda(u_two_wire_if.sda), .sda_tgt_oe_n(u_two_wire_if.sda_tgt_oe_n));

   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic close_out;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD at %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Polling is bounded; a transfer that never finishes ends the run.
   task automatic xfer(input logic op, input logic [1:0] idx, input logic [7:0] d);
      logic [7:0] s;
      int         n;
      wr(WDATA_OFS, d);
      wr(CMD_OFS, {4'h0, idx, op, 1'b1});
      n = 0;
      s = 8'hFF;
      while (s[0] !== 1'b0 && n < POLL_LIMIT)
      begin
         rd(STATUS_OFS, s);
         n++;
      end
      if (s[0] !== 1'b0)
      begin
         miscompares++;
         close_out();
      end
      else
         chk(s, 8'h00);
   endtask

   task automatic do_reset;
      rst <= 1'b1;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
   endtask

   initial
   begin
      rst = 1'b1;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      miscompares = 0;
      compares = 0;
      do_reset();
      chk({2'h0, spread_deep, spread_enable, diff_output_oe_n}, 8'h20);
      chk({4'h0, diff_output_p ^ diff_output_n}, 8'h0F);
      wr(STATUS_OFS, 8'hFF);
      rd(STATUS_OFS, got);
      chk(got, 8'h00);
      $display("test defaults done");
      xfer(1'b1, SPREAD_SPECTRUM_CONTROL_IDX, 8'h00);
      rd(RDATA_OFS, got);
      chk(got, 8'hEA);
      $display("test default read done");
      xfer(1'b0, OUTPUT_ENABLE_CONTROL_IDX, 8'h54);
      chk({2'h0, spread_deep, spread_enable, diff_output_oe_n}, 8'h25);
      xfer(1'b1, OUTPUT_ENABLE_CONTROL_IDX, 8'h00);
      rd(RDATA_OFS, got);
      chk(got, 8'h54);
      $display("test enable write done");
      xfer(1'b0, SPREAD_SPECTRUM_CONTROL_IDX, 8'h6E);
      chk({2'h0, spread_deep, spread_enable, diff_output_oe_n}, 8'h15);
      xfer(1'b1, RESERVED_CONTROL_THREE_IDX, 8'h00);
      rd(RDATA_OFS, got);
      chk(got, 8'h00);
      $display("test spread write done");
      do_reset();
      chk({2'h0, spread_deep, spread_enable, diff_output_oe_n}, 8'h20);
      xfer(1'b1, OUTPUT_ENABLE_CONTROL_IDX, 8'h00);
      rd(RDATA_OFS, got);
      chk(got, 8'h7C);
      $display("test second reset done");
      close_out();
   end
endmodule // tb
